// ---- func_cfg_regs.sv ----
// Function option and state registers with interrupt and status gating.
`timescale 1ns/1ps
module func_cfg_regs #(
  parameter int PULSE_LEN = func_cfg_pkg::PULSE_CYCLES,
  parameter int GAP_LEN = func_cfg_pkg::RETRIG_CYCLES
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Host card reset pin, active high, from outside the clock domain.
  input wire logic card_reset,
  // Host register access.
  input wire func_cfg_pkg::reg_access_t host_access,
  output logic [7:0] host_rdata,
  // Pin replacement change bits from the neighbouring register.
  input wire logic [7:0] pin_change_bits,
  input wire logic pin_change_clear,
  // Function side inputs, asynchronous pins.
  input wire logic function_interrupt_in,
  input wire logic speaker_input,
  input wire logic ready_busy_state,
  input wire logic power_manager_control,
  // Function side outputs.
  output func_cfg_pkg::func_ctrl_t func_ctrl,
  output logic function_power_control,
  output logic function_pins_float,
  output logic ready_busy_changed,
  // Host side pins, active low.
  output logic irq_req_n,
  output logic status_change_n,
  output logic speaker_out_n
);

  // ==========================================================================
  // Input synchronisers: three stages, a change counts when stages 2 and 3
  // agree.
  logic [2:0] rst_sync_reg;
  logic [2:0] function_interrupt_in_sync_reg;
  logic [2:0] spk_sync_reg;
  logic [2:0] rdy_sync_reg;
  logic card_rst_reg;
  logic card_rst_next;
  logic function_interrupt_in_reg;
  logic function_interrupt_in_next;
  logic spk_reg;
  logic spk_next;
  logic rdy_reg;
  logic rdy_next;

  // Filtered levels update only when the two late stages agree.
  always_comb begin
    card_rst_next = card_rst_reg;
    function_interrupt_in_next = function_interrupt_in_reg;
    spk_next = spk_reg;
    rdy_next = rdy_reg;
    if (rst_sync_reg[1] == rst_sync_reg[2]) begin
      card_rst_next = rst_sync_reg[2];
    end
    if (function_interrupt_in_sync_reg[1] == function_interrupt_in_sync_reg[2]) begin
      function_interrupt_in_next = function_interrupt_in_sync_reg[2];
    end
    if (spk_sync_reg[1] == spk_sync_reg[2]) begin
      spk_next = spk_sync_reg[2];
    end
    if (rdy_sync_reg[1] == rdy_sync_reg[2]) begin
      rdy_next = rdy_sync_reg[2];
    end
  end

  // Synchroniser registers.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rst_sync_reg <= 3'h0;
      function_interrupt_in_sync_reg <= 3'h0;
      spk_sync_reg <= 3'h0;
      rdy_sync_reg <= 3'h0;
      card_rst_reg <= 1'b0;
      function_interrupt_in_reg <= 1'b0;
      spk_reg <= 1'b0;
      rdy_reg <= 1'b0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[1:0], card_reset};
      function_interrupt_in_sync_reg <= {function_interrupt_in_sync_reg[1:0], function_interrupt_in};
      spk_sync_reg <= {spk_sync_reg[1:0], speaker_input};
      rdy_sync_reg <= {rdy_sync_reg[1:0], ready_busy_state};
      card_rst_reg <= card_rst_next;
      function_interrupt_in_reg <= function_interrupt_in_next;
      spk_reg <= spk_next;
      rdy_reg <= rdy_next;
    end
  end

  // ==========================================================================
  // Register file.
  logic [7:0] option_reg;
  logic [7:0] option_next;
  logic [7:0] state_reg;
  logic [7:0] state_next;
  logic rdy_last_reg;
  logic rdy_change_reg;
  logic rdy_change_next;
  logic retrig_reg;
  logic retrig_next;
  logic [2:0] settle_reg;
  logic [2:0] settle_next;
  logic wr_option;
  logic wr_state;
  logic configured;
  logic irq_enable;
  logic [7:0] wval;

  assign wr_option = host_access.wr &&
    host_access.addr == func_cfg_pkg::OPTION_OFFSET;
  assign wr_state = host_access.wr &&
    host_access.addr == func_cfg_pkg::STATE_OFFSET;
  assign configured = option_reg[func_cfg_pkg::OPT_CONFIGURED_BIT];
  assign irq_enable = option_reg[func_cfg_pkg::OPT_IRQ_ENABLE_BIT];
  assign wval = host_access.wdata;

  // Next values for both registers; the level select is protected, the
  // index is wiped by soft reset or card reset, and the pending bit is
  // driven by the interrupt input, never by a write.
  always_comb begin
    option_next = option_reg;
    state_next = state_reg;
    retrig_next = 1'b0;
    rdy_change_next = rdy_change_reg;
    settle_next = settle_reg;
    if (wr_option) begin
      option_next = wval & func_cfg_pkg::OPT_WRITE_MASK;
      option_next[func_cfg_pkg::OPT_LEVEL_SEL_BIT] =
        option_reg[func_cfg_pkg::OPT_LEVEL_SEL_BIT];
      if (configured && irq_enable) begin
        option_next[func_cfg_pkg::OPT_LEVEL_SEL_BIT] =
          wval[func_cfg_pkg::OPT_LEVEL_SEL_BIT];
      end
    end
    if (option_next[func_cfg_pkg::OPT_SOFT_RESET_BIT] || card_rst_reg) begin
      option_next[5:0] = 6'h00;
    end
    if (wr_state) begin
      state_next = (wval & func_cfg_pkg::ST_WRITE_MASK) |
        (state_reg & 8'h82);
      if (state_reg[func_cfg_pkg::ST_RETRIGGER_BIT] &&
          !wval[func_cfg_pkg::ST_PENDING_BIT]) begin
        retrig_next = 1'b1;
      end
    end
    state_next[func_cfg_pkg::ST_PENDING_BIT] = function_interrupt_in_reg;
    // The change detector waits until the synchroniser has filled, because
    // its stages reset low while the pin idles high; otherwise leaving
    // reset would itself look like a ready/busy change.
    if (settle_reg != 3'h7) begin
      settle_next = settle_reg + 3'h1;
    end
    if (pin_change_clear) begin
      rdy_change_next = 1'b0;
    end
    if (settle_reg == 3'h7 && rdy_reg != rdy_last_reg) begin
      rdy_change_next = 1'b1;
    end
    state_next[func_cfg_pkg::ST_CHANGED_BIT] =
      |{pin_change_bits, rdy_change_reg};
  end

  // Register updates; a soft reset clears only the option index bits and leaves the
  // state register alone so that the device itself keeps running.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      option_reg <= func_cfg_pkg::OPTION_RESET;
      state_reg <= func_cfg_pkg::STATE_RESET;
      rdy_last_reg <= 1'b0;
      rdy_change_reg <= 1'b0;
      retrig_reg <= 1'b0;
      settle_reg <= 3'h0;
    end else begin
      option_reg <= option_next;
      state_reg <= state_next;
      rdy_last_reg <= rdy_reg;
      rdy_change_reg <= rdy_change_next;
      retrig_reg <= retrig_next;
      settle_reg <= settle_next;
    end
  end

  // ==========================================================================
  // Read data, registered.
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Unmapped addresses read as zero.
  always_comb begin
    rdata_next = 8'h00;
    if (host_access.rd) begin
      if (host_access.addr == func_cfg_pkg::OPTION_OFFSET) begin
        rdata_next = option_reg;
      end else if (host_access.addr == func_cfg_pkg::STATE_OFFSET) begin
        rdata_next = state_reg;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign host_rdata = rdata_reg;

  // ==========================================================================
  // Function control and pin outputs, registered.
  logic io_mode;
  logic power_down;
  func_cfg_pkg::func_ctrl_t ctrl_reg;
  func_cfg_pkg::func_ctrl_t ctrl_next;
  logic pwr_reg;
  logic pwr_next;
  logic stschg_n_reg;
  logic stschg_n_next;
  logic spk_n_reg;
  logic spk_n_next;

  assign io_mode = option_reg[5:0] != 6'h00;
  assign power_down = state_reg[func_cfg_pkg::ST_POWER_DOWN_BIT];

  // Outputs to the function and to the host side pins.
  always_comb begin
    ctrl_next.func_reset = option_reg[func_cfg_pkg::OPT_SOFT_RESET_BIT] ||
      card_rst_reg;
    ctrl_next.io_enable = io_mode && configured && !power_down;
    ctrl_next.window_check = option_reg[func_cfg_pkg::OPT_WINDOW_BIT];
    ctrl_next.power_manager = option_reg[func_cfg_pkg::OPT_PWR_MGR_BIT];
    ctrl_next.test_mode = option_reg[func_cfg_pkg::OPT_TEST_BIT];
    if (power_down) begin
      pwr_next = 1'b0;
    end else if (option_reg[func_cfg_pkg::OPT_PWR_MGR_BIT]) begin
      pwr_next = power_manager_control;
    end else begin
      pwr_next = 1'b1;
    end
    stschg_n_next = !(io_mode && state_reg[func_cfg_pkg::ST_CHANGED_BIT] &&
      state_reg[func_cfg_pkg::ST_GATE_BIT]);
    spk_n_next = !(state_reg[func_cfg_pkg::ST_AUDIO_BIT] && configured &&
      spk_reg);
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl_reg <= '0;
      pwr_reg <= 1'b0;
      stschg_n_reg <= 1'b1;
      spk_n_reg <= 1'b1;
    end else begin
      ctrl_reg <= ctrl_next;
      pwr_reg <= pwr_next;
      stschg_n_reg <= stschg_n_next;
      spk_n_reg <= spk_n_next;
    end
  end

  assign func_ctrl = ctrl_reg;
  assign function_power_control = pwr_reg;
  assign function_pins_float = power_down;
  assign ready_busy_changed = rdy_change_reg;
  assign status_change_n = stschg_n_reg;
  assign speaker_out_n = spk_n_reg;

  // ==========================================================================
  // Interrupt generation; the request is gated by the enable so a polling
  // driver sees the pending bit without host interrupts.
  logic irq_request;

  assign irq_request = function_interrupt_in_reg && irq_enable && configured && io_mode;

  irq_pulse_gen #(
    .PULSE_LEN(PULSE_LEN),
    .GAP_LEN(GAP_LEN)
  ) u_irq (
    .clk_sys(clk_sys),
    .srst(srst),
    .level_mode(option_reg[func_cfg_pkg::OPT_LEVEL_SEL_BIT]),
    .request(irq_request),
    .retrigger(retrig_reg),
    .irq_req_n(irq_req_n)
  );

endmodule

// ---- func_cfg_pkg.sv ----
// Package with offsets, field positions, reset values, timing and carriers.
package func_cfg_pkg;

  // ==========================================================================
  // Register offsets.
  localparam logic [15:0] OPTION_OFFSET = 16'h1020;
  localparam logic [15:0] STATE_OFFSET = 16'h1022;

  // ==========================================================================
  // Option register fields.
  localparam int OPT_SOFT_RESET_BIT = 7;
  localparam int OPT_LEVEL_SEL_BIT = 6;
  localparam int OPT_CONFIGURED_BIT = 0;
  localparam int OPT_WINDOW_BIT = 1;
  localparam int OPT_IRQ_ENABLE_BIT = 2;
  localparam int OPT_PWR_MGR_BIT = 3;
  localparam int OPT_TEST_BIT = 4;
  localparam logic [7:0] OPT_WRITE_MASK = 8'hDF;
  localparam logic [7:0] OPTION_RESET = 8'h00;

  // ==========================================================================
  // State register fields.
  localparam int ST_CHANGED_BIT = 7;
  localparam int ST_GATE_BIT = 6;
  localparam int ST_BYTE_PATH_BIT = 5;
  localparam int ST_AUDIO_BIT = 3;
  localparam int ST_POWER_DOWN_BIT = 2;
  localparam int ST_PENDING_BIT = 1;
  localparam int ST_RETRIGGER_BIT = 0;
  localparam logic [7:0] ST_WRITE_MASK = 8'h6D;
  localparam logic [7:0] STATE_RESET = 8'h00;

  // ==========================================================================
  // Timing: pulse width in clocks, retrigger release time in ns.
  localparam int CLK_PERIOD_NS = 10;
  localparam int PULSE_CYCLES = 16;
  localparam int RETRIG_LOW_NS = 500;
  localparam int RETRIG_CYCLES =
    (RETRIG_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // Host register access carrier.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } reg_access_t;

  // Function-side control carrier.
  typedef struct packed {
    logic func_reset;
    logic io_enable;
    logic window_check;
    logic power_manager;
    logic test_mode;
  } func_ctrl_t;

endpackage

// ---- irq_pulse_gen.sv ----
// Interrupt request pin generator for level, pulse and retrigger modes.
`timescale 1ns/1ps
module irq_pulse_gen #(
  parameter int PULSE_LEN = func_cfg_pkg::PULSE_CYCLES,
  parameter int GAP_LEN = func_cfg_pkg::RETRIG_CYCLES
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Control.
  input wire logic level_mode,
  input wire logic request,
  input wire logic retrigger,
  // Pin, active low.
  output logic irq_req_n
);

  localparam int CW = $clog2(PULSE_LEN + GAP_LEN + 1);

  initial begin
    if (PULSE_LEN < 1 || GAP_LEN < 1) begin
      $error("irq_pulse_gen: lengths must be at least one");
    end
  end

  typedef enum logic [1:0] {IDLE, PULSE, GAP, HOLD} irq_state_t;

  irq_state_t state_reg;
  irq_state_t state_next;
  logic [CW-1:0] count_reg;
  logic [CW-1:0] count_next;
  logic req_d_reg;
  logic irq_n_reg;
  logic irq_n_next;

  // Next state: pulse mode fires a fixed pulse, level mode follows request,
  // and in level mode a retrigger releases the pin for a gap before asserting again.
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    irq_n_next = 1'b1;
    unique case (state_reg)
      IDLE: begin
        // Level mode follows the request itself, so switching to level mode
        // while a request is already up still asserts the pin.
        if (level_mode ? request : (request && !req_d_reg)) begin
          count_next = '0;
          state_next = level_mode ? HOLD : PULSE;
        end
      end
      PULSE: begin
        // The pin stays low through the last count for a full width.
        irq_n_next = 1'b0;
        count_next = count_reg + 1'b1;
        if (count_reg == CW'(PULSE_LEN - 1)) begin
          state_next = IDLE;
        end
      end
      HOLD: begin
        irq_n_next = 1'b0;
        if (!request || !level_mode) begin
          state_next = IDLE;
          irq_n_next = 1'b1;
        end else if (retrigger) begin
          count_next = '0;
          state_next = GAP;
          irq_n_next = 1'b1;
        end
      end
      GAP: begin
        // Level mode releases the pin here; pulse mode holds it low, since
        // the short pulse would miss the minimum retrigger low time.
        irq_n_next = level_mode;
        count_next = count_reg + 1'b1;
        if (count_reg == CW'(GAP_LEN - 1)) begin
          state_next = IDLE;
        end
      end
    endcase
    if (retrigger && request && state_reg == IDLE) begin
      count_next = '0;
      state_next = GAP;
    end
    if (state_reg == GAP && count_reg == CW'(GAP_LEN - 1) && request &&
        level_mode) begin
      count_next = '0;
      state_next = HOLD;
      irq_n_next = 1'b0;
    end
  end

  // Registers.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= IDLE;
      count_reg <= '0;
      req_d_reg <= 1'b0;
      irq_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      req_d_reg <= request;
      irq_n_reg <= irq_n_next;
    end
  end

  assign irq_req_n = irq_n_reg;

endmodule

// ---- func_cfg_props.sv ----
// Assertion checker for the function option and state registers.
`timescale 1ns/1ps
module func_cfg_props #(
  parameter int PULSE_LEN = func_cfg_pkg::PULSE_CYCLES,
  parameter int GAP_LEN = func_cfg_pkg::RETRIG_CYCLES
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic srst,
  // Host side inputs.
  input wire func_cfg_pkg::reg_access_t host_access,
  input wire logic [7:0] pin_change_bits,
  // Observed outputs.
  input wire func_cfg_pkg::func_ctrl_t func_ctrl,
  input wire logic function_power_control,
  input wire logic function_pins_float,
  input wire logic irq_req_n,
  input wire logic status_change_n
);
  // ==========================================================================
  // Shadow of the host writes.
  logic wo, ws, sr_reg, lvl_reg, cfg_reg, ien_reg, gate_reg, pd_reg;
  logic rt_reg, rtm_reg, irq_d_reg;
  logic [7:0] d;
  logic [15:0] lows_reg;
  assign d = host_access.wdata;
  assign wo = host_access.wr &&
    host_access.addr == func_cfg_pkg::OPTION_OFFSET;
  assign ws = host_access.wr &&
    host_access.addr == func_cfg_pkg::STATE_OFFSET;

  // The shadow ignores card reset, so the bench uses that pin last.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      {sr_reg, lvl_reg, cfg_reg, ien_reg, gate_reg, pd_reg} <= 6'h00;
      rt_reg <= 1'b0;
      rtm_reg <= 1'b0;
      irq_d_reg <= 1'b1;
      lows_reg <= 16'h0000;
    end else begin
      if (wo) begin
        sr_reg <= d[7];
        if (cfg_reg && ien_reg) lvl_reg <= d[6];
        cfg_reg <= d[0] && !d[7];
        ien_reg <= d[2] && !d[7];
      end
      if (ws) begin
        gate_reg <= d[6];
        pd_reg <= d[2];
        rtm_reg <= d[0];
      end
      // A retrigger needs the mode bit already held, not the one written.
      if (ws && rtm_reg && !d[1]) rt_reg <= 1'b1;
      else if (irq_req_n && !irq_d_reg) rt_reg <= 1'b0;
      irq_d_reg <= irq_req_n;
      lows_reg <= irq_req_n ? 16'h0000 : lows_reg + 16'h0001;
    end
  end

  // ==========================================================================
  // Properties.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  AST_SOFT_RESET: assert property (
    sr_reg && $past(sr_reg) |-> func_ctrl.func_reset)
    else $error("function left out of reset");
  AST_INDEX_CLEAR: assert property (
    sr_reg && $past(sr_reg) |-> !func_ctrl.io_enable)
    else $error("index not cleared by soft reset");
  AST_GATE_OFF: assert property (
    !gate_reg [*3] |-> status_change_n)
    else $error("status change pin low without gate");
  AST_GATE_ON: assert property (
    (gate_reg && |pin_change_bits) [*3] |-> ##[0:2] !status_change_n)
    else $error("status change pin not asserted");
  AST_POWER_DOWN: assert property (
    pd_reg [*2] |-> function_pins_float && !function_power_control)
    else $error("function still powered");
  AST_PULSE_WIDTH: assert property (
    !lvl_reg && !rt_reg && $rose(irq_req_n) |-> lows_reg == PULSE_LEN)
    else $error("interrupt pulse width wrong");
  AST_RETRIG_LOW: assert property (
    !lvl_reg && rt_reg && $rose(irq_req_n) |-> lows_reg >= GAP_LEN)
    else $error("retrigger low phase too short");
  AST_LEVEL_REARM: assert property (
    lvl_reg && rt_reg && $rose(irq_req_n) |-> ##[1:64] !irq_req_n)
    else $error("level retrigger did not reassert");
  AST_IRQ_MASKED: assert property (
    !ien_reg [*3] |-> irq_req_n)
    else $error("interrupt raised while disabled");
endmodule

// ---- func_side_model.sv ----
// Behavioural model of the card function behind the block.
`timescale 1ns/1ps
module func_side_model (
  // Clock and commands.
  input wire logic clk_sys,
  input wire logic raise_irq,
  input wire logic service_irq,
  input wire logic flip_ready,
  input wire logic spk_level,
  // Function pins.
  output logic function_interrupt_in,
  output logic speaker_input,
  output logic ready_busy_state
);
  // The interrupt stays asserted until its driver services it.
  initial begin
    function_interrupt_in = 1'b0;
    speaker_input = 1'b0;
    ready_busy_state = 1'b1;
  end
  always @(posedge clk_sys) begin
    if (raise_irq) function_interrupt_in <= 1'b1;
    else if (service_irq) function_interrupt_in <= 1'b0;
    if (flip_ready) ready_busy_state <= !ready_busy_state;
    speaker_input <= spk_level;
  end
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the function option and state registers.
`timescale 1ns/1ps
module tb_top;
  localparam logic [15:0] OPT = func_cfg_pkg::OPTION_OFFSET;
  localparam logic [15:0] ST = func_cfg_pkg::STATE_OFFSET;
  localparam int PULSE = func_cfg_pkg::PULSE_CYCLES;
  localparam int GAP = func_cfg_pkg::RETRIG_CYCLES;
  logic clk_sys, srst, card_reset, pin_change_clear, power_manager_control;
  logic raise_irq, service_irq, flip_ready, spk_level;
  logic function_interrupt_in, speaker_input, ready_busy_state;
  logic function_power_control, function_pins_float, ready_busy_changed;
  logic irq_req_n, status_change_n, speaker_out_n;
  logic [7:0] host_rdata, pin_change_bits;
  func_cfg_pkg::reg_access_t host_access;
  func_cfg_pkg::func_ctrl_t func_ctrl;
  int num_errors = 0;
  int checks_done = 0;
  int n;

  func_cfg_regs i_func_cfg_regs (.clk_sys, .srst, .card_reset,
    .host_access, .host_rdata, .pin_change_bits, .pin_change_clear,
    .function_interrupt_in, .speaker_input, .ready_busy_state,
    .power_manager_control, .func_ctrl, .function_power_control,
    .function_pins_float, .ready_busy_changed, .irq_req_n,
    .status_change_n, .speaker_out_n);
  func_side_model i_func_side_model (.clk_sys, .raise_irq, .service_irq,
    .flip_ready, .spk_level, .function_interrupt_in, .speaker_input,
    .ready_busy_state);

  // Free-running 100 MHz clock.
  always #5 clk_sys = ~clk_sys;

  // ==========================================================================
  // Shared tasks.
  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    host_access <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    host_access <= '0;
    @(posedge clk_sys);
    // Registered outputs follow the register one edge later.
    @(posedge clk_sys);
  endtask
  // Read data stands one cycle, so it is sampled just after its edge.
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    host_access <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    host_access <= '0;
    #1;
    check(host_rdata === e, "read data mismatch");
    @(posedge clk_sys);
  endtask
  function automatic logic sig(input int k);
    case (k)
      0: return irq_req_n;
      1: return status_change_n;
      default: return ready_busy_changed;
    endcase
  endfunction
  task automatic wait_for(input int k, input logic v, input int lim);
    n = 0;
    while (sig(k) !== v) begin
      if (n == lim) begin
        num_errors++;
        $display("unexpected at %0t: wait timed out", $time);
        close_out();
      end
      @(posedge clk_sys);
      n++;
    end
  endtask
  task automatic hold(input int k, input logic v, input int c);
    repeat (c) begin
      @(posedge clk_sys);
      check(sig(k) === v, "signal left its level");
    end
  endtask
  task automatic fn_irq(input logic up);
    raise_irq <= up;
    service_irq <= !up;
    @(posedge clk_sys);
    raise_irq <= 1'b0;
    service_irq <= 1'b0;
    hold(0, irq_req_n, 0);
    repeat (4) @(posedge clk_sys);
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_regs();
    rd(OPT, 8'h00);
    rd(ST, 8'h00);
    wr(OPT, 8'h2E);
    rd(OPT, 8'h0E);
    wr(ST, 8'hF9);
    rd(ST, 8'h69);
    rd(16'h1021, 8'h00);
    wr(ST, 8'h02);
    wr(OPT, 8'h40);
    rd(OPT, 8'h00);
    wr(OPT, 8'h05);
    wr(OPT, 8'h45);
    rd(OPT, 8'h45);
    wr(OPT, 8'h05);
    rd(OPT, 8'h05);
  endtask
  task automatic t_pulse();
    fn_irq(1'b1);
    wait_for(0, 1'b0, 20);
    wait_for(0, 1'b1, 40);
    check(n == PULSE, "pulse width");
    rd(ST, 8'h02);
    wr(ST, 8'h00);
    hold(0, 1'b1, 60);
    wr(OPT, 8'h01);
    fn_irq(1'b0);
    fn_irq(1'b1);
    hold(0, 1'b1, 40);
    fn_irq(1'b0);
  endtask
  // Retrigger in pulse mode, then in level mode with the input held.
  task automatic t_retrig();
    wr(OPT, 8'h05);
    fn_irq(1'b1);
    wait_for(0, 1'b0, 20);
    wait_for(0, 1'b1, 40);
    wr(ST, 8'h01);
    wr(ST, 8'h01);
    wait_for(0, 1'b0, 10);
    wait_for(0, 1'b1, 200);
    check(n >= GAP, "retrigger low time");
    wr(OPT, 8'h45);
    wait_for(0, 1'b0, 10);
    wr(ST, 8'h01);
    wait_for(0, 1'b1, 10);
    wait_for(0, 1'b0, 100);
    hold(0, 1'b0, 20);
    fn_irq(1'b0);
    wait_for(0, 1'b1, 10);
    wr(OPT, 8'h05);
    wr(ST, 8'h02);
  endtask
  task automatic t_status();
    wr(OPT, 8'h01);
    check(func_ctrl.window_check === 1'b0, "window check on");
    wr(ST, 8'h40);
    pin_change_bits <= 8'h20;
    wait_for(1, 1'b0, 8);
    rd(ST, 8'hC0);
    wr(ST, 8'h00);
    wait_for(1, 1'b1, 8);
    pin_change_bits <= 8'h00;
    flip_ready <= 1'b1;
    @(posedge clk_sys);
    flip_ready <= 1'b0;
    wait_for(2, 1'b1, 10);
    rd(ST, 8'h80);
    pin_change_clear <= 1'b1;
    @(posedge clk_sys);
    pin_change_clear <= 1'b0;
    wait_for(2, 1'b0, 5);
  endtask
  task automatic t_power();
    wr(ST, 8'h04);
    check(function_pins_float === 1'b1, "pins driven");
    check(function_power_control === 1'b0, "still powered");
    wr(ST, 8'h08);
    wr(OPT, 8'h09);
    repeat (2) @(posedge clk_sys);
    check(func_ctrl.power_manager === 1'b1, "manager off");
    check(function_power_control === 1'b0, "manager ignored");
    power_manager_control <= 1'b1;
    spk_level <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check(function_power_control === 1'b1, "manager ignored");
    check(speaker_out_n === 1'b0, "speaker not routed");
    spk_level <= 1'b0;
    repeat (8) @(posedge clk_sys);
    check(speaker_out_n === 1'b1, "speaker not routed");
  endtask
  task automatic t_reset();
    wr(OPT, 8'h03);
    check(func_ctrl.window_check === 1'b1, "window check off");
    check(func_ctrl.io_enable === 1'b1, "io not enabled");
    wr(OPT, 8'h87);
    check(func_ctrl.func_reset === 1'b1, "no soft reset");
    rd(OPT, 8'h80);
    wr(OPT, 8'h00);
    check(func_ctrl.func_reset === 1'b0, "stuck in reset");
    check(func_ctrl.io_enable === 1'b0, "io enabled");
    wr(OPT, 8'h03);
    card_reset <= 1'b1;
    repeat (6) @(posedge clk_sys);
    card_reset <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rd(OPT, 8'h00);
    check(func_ctrl.io_enable === 1'b0, "io enabled");
  endtask

  task automatic close_out();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence after a two-cycle reset.
  initial begin
    clk_sys = 1'b0;
    srst = 1'b1;
    {card_reset, pin_change_clear, power_manager_control} = 3'h0;
    {raise_irq, service_irq, flip_ready, spk_level} = 4'h0;
    pin_change_bits = 8'h00;
    host_access = '0;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    t_regs();
    t_pulse();
    t_retrig();
    t_status();
    t_power();
    t_reset();
    close_out();
  end
endmodule

bind func_cfg_regs func_cfg_props #(.PULSE_LEN(PULSE_LEN),
  .GAP_LEN(GAP_LEN)) i_func_cfg_props (.clk_sys, .srst, .host_access,
  .pin_change_bits, .func_ctrl, .function_power_control,
  .function_pins_float, .irq_req_n, .status_change_n);
